// >>> rtl/tlsx_top.v
// three-lane 7x serializer with forwarded frame clock
`timescale 1ns/1ps
`default_nettype none
`include "tlsx_defines.vh"
module tlsx_top (
	input  wire                      clk_i,
	input  wire                      arst_n_i,
	input  wire                      frame_clock_in_i,
	input  wire [`TLSX_WORD_W-1:0]   parallel_data_in_i,
	input  wire                      lane_hold_i,
	output wire                      word_ready_o,
	output wire [`TLSX_LANES-1:0]    serial_lane_out_o,
	output reg                       forwarded_frame_clock_o,
	output reg                       line_drv_en_n_o
);
	// ******************************
	// input synchronisers
	// ******************************
	localparam ST_IDLE  = 1'b0;
	localparam ST_SHIFT = 1'b1;

	reg                     fc_s1_r;
	reg                     fc_s2_r;
	reg                     fc_s3_r;
	reg  [`TLSX_WORD_W-1:0] dat_s1_r;
	reg  [`TLSX_WORD_W-1:0] dat_s2_r;
	reg                     hold_s1_r;
	reg                     hold_s2_r;
	wire                    frame_rise;

	// frame clock: two stages against metastability, a third to find the edge
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fc_s1_r <= 1'b0;
			fc_s2_r <= 1'b0;
			fc_s3_r <= 1'b0;
		end else begin
			fc_s1_r <= frame_clock_in_i;
			fc_s2_r <= fc_s1_r;
			fc_s3_r <= fc_s2_r;
		end
	end

	// data passes the same two stages as the frame clock so both stay aligned;
	// the word is only sound if the source holds it steady around the edge
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dat_s1_r <= `TLSX_WORD_RST;
			dat_s2_r <= `TLSX_WORD_RST;
		end else begin
			dat_s1_r <= parallel_data_in_i;
			dat_s2_r <= dat_s1_r;
		end
	end

	// receiver hold stops the next word only; a word already going out completes
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hold_s1_r <= 1'b0;
			hold_s2_r <= 1'b0;
		end else begin
			hold_s1_r <= lane_hold_i;
			hold_s2_r <= hold_s1_r;
		end
	end

	// edge stage resets low like the idle pin, so no false edge follows reset
	assign frame_rise = fc_s2_r & ~fc_s3_r;

	// ******************************
	// holding buffer
	// ******************************
	wire                    buf_valid;
	wire [`TLSX_WORD_W-1:0] buf_word;
	wire                    load;
	reg                     state_r;

	// whole word goes in on each frame edge; words at a full buffer are lost
	tlsx_buf u_buf (
		.clk_i       (clk_i),
		.arst_n_i    (arst_n_i),
		.in_valid_i  (frame_rise),
		.in_data_i   (dat_s2_r),
		.in_ready_o  (word_ready_o),
		.out_valid_o (buf_valid),
		.out_data_o  (buf_word),
		.out_ready_i (load)
	);

	// a receiver hold keeps words in the buffer instead of dropping them
	assign load = buf_valid & ~hold_s2_r & (state_r == ST_IDLE);

	// ******************************
	// lane decode
	// ******************************
	// slice of the captured word that one lane carries
	function [`TLSX_SLICE_W-1:0] lane_slice;
		input [`TLSX_WORD_W-1:0] word;
		input integer            lane;
		begin
			lane_slice = word[lane*`TLSX_SLICE_W +: `TLSX_SLICE_W];
		end
	endfunction

	// ******************************
	// bit sequencer state
	// ******************************
	// counter is 0 when idle and runs 1..6 while shifting
	reg                     state_nxt;
	reg  [`TLSX_CNT_W-1:0]  bit_cnt_r;
	reg  [`TLSX_CNT_W-1:0]  bit_cnt_nxt;
	reg                     fwd_nxt;
	wire                    in_shift;
	wire                    last_bit;

	assign in_shift = (state_r == ST_SHIFT);
	assign last_bit = (bit_cnt_r == `TLSX_LAST_BIT);

	// ******************************
	// shift registers and lanes
	// ******************************
	genvar g;
	generate
		for (g = 0; g < `TLSX_LANES; g = g + 1) begin : g_lane
			wire [`TLSX_SLICE_W-1:0] slice;
			reg  [`TLSX_SLICE_W-1:0] sh_r;
			reg  [`TLSX_SLICE_W-1:0] sh_nxt;
			reg                      bit_r;
			reg                      bit_nxt;

			// raw slice, no coding or overhead
			assign slice = lane_slice(buf_word, g);

			always @* begin
				sh_nxt  = sh_r;
				bit_nxt = bit_r;
				if (load) begin
					sh_nxt  = slice;
					bit_nxt = slice[0];
				end else if (in_shift) begin
					// lsb first: one bit per lane per bit period
					sh_nxt  = {1'b0, sh_r[`TLSX_SLICE_W-1:1]};
					bit_nxt = sh_r[1];
				end
			end

			always @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					sh_r  <= `TLSX_SLICE_RST;
					bit_r <= 1'b0;
				end else begin
					sh_r  <= sh_nxt;
					bit_r <= bit_nxt;
				end
			end

			// idle lanes keep the last bit; one flip-flop and one driver per pin
			assign serial_lane_out_o[g] = bit_r;
		end
	endgenerate

	// ******************************
	// bit sequencer and forwarded clock
	// ******************************
	// bit period is one clk_i cycle; the frame must last at least seven cycles,
	// spare cycles idle with the forwarded clock low
	// forwarded clock is high on bits 0..3 of a word and low on bits 4..6
	always @* begin
		state_nxt   = state_r;
		bit_cnt_nxt = bit_cnt_r;
		fwd_nxt     = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (load) begin
					state_nxt   = ST_SHIFT;
					bit_cnt_nxt = `TLSX_CNT_FIRST;
					fwd_nxt     = 1'b1;
				end
			end
			ST_SHIFT: begin
				fwd_nxt     = (bit_cnt_r < `TLSX_FWD_HIGH);
				bit_cnt_nxt = bit_cnt_r + `TLSX_CNT_STEP;
				if (last_bit) begin
					state_nxt   = ST_IDLE;
					bit_cnt_nxt = `TLSX_CNT_RST;
				end
			end
			default: begin
				state_nxt   = ST_IDLE;
				bit_cnt_nxt = `TLSX_CNT_RST;
			end
		endcase
	end

	// registered so the forwarded clock never glitches on decode
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r                 <= ST_IDLE;
			bit_cnt_r               <= `TLSX_CNT_RST;
			forwarded_frame_clock_o <= 1'b0;
		end else begin
			state_r                 <= state_nxt;
			bit_cnt_r               <= bit_cnt_nxt;
			forwarded_frame_clock_o <= fwd_nxt;
		end
	end

	// ******************************
	// line drivers
	// ******************************
	// drivers stay off through reset so a shut-down link draws no line current
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			line_drv_en_n_o <= 1'b1;
		else
			line_drv_en_n_o <= 1'b0;
	end
endmodule // tlsx_top
`default_nettype wire

// >>> rtl/tlsx_defines.vh
// constants of the three-lane 7x serializer
// Notes on behaviour
// - Capture all 21 parallel bits on every rising edge of the frame clock while the two-entry buffer has room.
// - Three independent 7-bit shift registers, loaded in parallel, emptied serially.
// - Bit rate is seven bits per lane per frame.
// - Drive three data lanes plus a forwarded clock at the frame rate.
// - Shutdown low stops clocking and disables all four line drivers.
// - Shutdown low asynchronously zeroes every holding and shift register.
// - Bits are sent unencoded, with no scrambling or overhead.
`ifndef TLSX_DEFINES_VH
`define TLSX_DEFINES_VH
`define TLSX_WORD_W    21
`define TLSX_SLICE_W   7
`define TLSX_LANES     3
`define TLSX_CNT_W     3
`define TLSX_CNT_RST   3'h0
`define TLSX_CNT_FIRST 3'h1
`define TLSX_CNT_STEP  3'h1
`define TLSX_LAST_BIT  3'h6
`define TLSX_FWD_HIGH  3'h4
`define TLSX_WORD_RST  21'h000000
`define TLSX_SLICE_RST 7'h00
`define TLSX_BUF_DEPTH 2'h2
`define TLSX_FRAME_MIN_MHZ 20
`define TLSX_FRAME_MAX_MHZ 68
`endif

// >>> rtl/tlsx_buf.v
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
`include "tlsx_defines.vh"
module tlsx_buf (
	input  wire                      clk_i,
	input  wire                      arst_n_i,
	input  wire                      in_valid_i,
	input  wire [`TLSX_WORD_W-1:0]   in_data_i,
	output reg                       in_ready_o,
	output wire                      out_valid_o,
	output wire [`TLSX_WORD_W-1:0]   out_data_o,
	input  wire                      out_ready_i
);
	reg  [`TLSX_WORD_W-1:0] mem_r [0:1];
	reg                     wr_ptr_r;
	reg                     rd_ptr_r;
	reg  [1:0]              cnt_r;
	reg  [1:0]              cnt_nxt;
	wire                    push;
	wire                    pop;
	integer                 i;

	assign out_valid_o = (cnt_r != 2'h0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	always @* begin
		cnt_nxt = cnt_r;
		if (push & ~pop)
			cnt_nxt = cnt_r + 2'h1;
		else if (pop & ~push)
			cnt_nxt = cnt_r - 2'h1;
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (i = 0; i < 2; i = i + 1)
				mem_r[i] <= `TLSX_WORD_RST;
			wr_ptr_r   <= 1'b0;
			rd_ptr_r   <= 1'b0;
			cnt_r      <= 2'h0;
			in_ready_o <= 1'b0;
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= in_data_i;
				wr_ptr_r        <= ~wr_ptr_r;
			end
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			cnt_r      <= cnt_nxt;
			// registered ready: full shows one cycle after the second push
			in_ready_o <= (cnt_nxt != `TLSX_BUF_DEPTH);
		end
	end
endmodule // tlsx_buf
`default_nettype wire

// >>> dv/tlsx_properties.sv
// port checker of the serializer
`timescale 1ns/1ps
`default_nettype none
module tlsx_properties (
	input wire logic       clk_i,
	input wire logic       arst_n_i,
	input wire logic       frame_clock_in_i,
	input wire logic       lane_hold_i,
	input wire logic       word_ready_o,
	input wire logic [2:0] serial_lane_out_o,
	input wire logic       forwarded_frame_clock_o,
	input wire logic       line_drv_en_n_o
);
	wire f = forwarded_frame_clock_o;
	wire [2:0] s = serial_lane_out_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	AST_CLR: assert property (disable iff (1'b0) !arst_n_i |-> line_drv_en_n_o && s == 3'h0 && !f)
		else $error("not cleared");
	AST_DRV: assert property ($past(arst_n_i) |-> !line_drv_en_n_o) else $error("drivers off");
	AST_OFF: assert property (line_drv_en_n_o |-> !f && s == 3'h0) else $error("lanes live");
	AST_HI4: assert property ($rose(f) |-> f [*4] ##1 !f) else $error("high phase");
	AST_LO3: assert property ($fell(f) |-> !f [*3]) else $error("low phase");
	AST_SLOT: assert property ($rose(f) |=> !$rose(f) [*6]) else $error("slot short");
	// four low cycles in a row can only be idle, where the lanes must not toggle
	AST_IDLE: assert property (!f && !$past(f) && !$past(f, 2) && !$past(f, 3) |-> $stable(s))
		else $error("idle toggle");
	AST_GO: assert property ($rose(frame_clock_in_i) && word_ready_o && !lane_hold_i |-> ##[3:20] $rose(f))
		else $error("no launch");
endmodule // tlsx_properties
bind tlsx_top tlsx_properties u_props (.clk_i(clk_i), .arst_n_i(arst_n_i), .frame_clock_in_i(frame_clock_in_i),
	.lane_hold_i(lane_hold_i), .word_ready_o(word_ready_o), .serial_lane_out_o(serial_lane_out_o),
	.forwarded_frame_clock_o(forwarded_frame_clock_o), .line_drv_en_n_o(line_drv_en_n_o));
`default_nettype wire

// >>> dv/tlsx_rx_model.sv
// receiving-end model rebuilding words
`timescale 1ns/1ps
`default_nettype none
module tlsx_rx_model (
	input  wire logic        clk_i,
	input  wire logic [2:0]  lanes_i,
	input  wire logic        fwd_i,
	output var  logic [20:0] word_o,
	output var  logic        got_o
);
	int   k = 7;
	logic q = 1'b0;
	initial word_o = 21'h000000;
	initial got_o = 1'b0;
	always @(posedge clk_i) begin
		got_o <= 1'b0;
		if (fwd_i === 1'b1 && q === 1'b0) k = 0;
		q <= fwd_i;
		if (k < 7) begin
			for (int g = 0; g < 3; g++) word_o[7*g+k] <= lanes_i[g];
			k++;
			got_o <= (k == 7);
		end
	end
endmodule // tlsx_rx_model
`default_nettype wire

// >>> dv/test_tlsx_top.sv
// self-checking bench of the serializer
`timescale 1ns/1ps
`default_nettype none
module test_tlsx_top;
	logic clk_i = 0, arst_n_i = 1, fc = 0, hold = 0, rdy, fwd, drv_n, got;
	logic [20:0] d = 21'h000000, rx, rq[$];
	logic [2:0] ln;
	int fails = 0, n_tests = 0;
	always #10 clk_i = ~clk_i;
	tlsx_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .frame_clock_in_i(fc), .parallel_data_in_i(d),
		.lane_hold_i(hold), .word_ready_o(rdy), .serial_lane_out_o(ln), .forwarded_frame_clock_o(fwd),
		.line_drv_en_n_o(drv_n));
	tlsx_rx_model u_rx (.clk_i(clk_i), .lanes_i(ln), .fwd_i(fwd), .word_o(rx), .got_o(got));
	always @(posedge clk_i) if (got === 1'b1) rq.push_back(rx);
	task automatic chk(input string w, input logic [20:0] e, input logic [20:0] s);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h seen %h", w, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// data inverted after the frame so a stuck capture cannot pass
	task automatic send(input logic [20:0] w);
		d = w;
		cyc(3);
		// steady 160 ns frame period, one cycle above the 140 ns that one bit per clk_i allows
		fc = 1'b1;
		cyc(4);
		fc = 1'b0;
		cyc(1);
		d = ~w;
	endtask
	task automatic expect_word(input logic [20:0] w);
		for (int i = 0; i < 40 && rq.size() == 0; i++) cyc(1);
		if (rq.size() == 0) rq.push_back(~w);
		chk("word", w, rq.pop_front());
	endtask
	task automatic t_reset;
		#1 arst_n_i = 1'b0;
		cyc(4);
		chk("drv_n", 21'h1, drv_n);
		chk("ready", 21'h0, rdy);
		arst_n_i = 1'b1;
		cyc(2);
		chk("drv_n", 21'h0, drv_n);
		chk("ready", 21'h1, rdy);
	endtask
	task automatic t_stream;
		logic [20:0] t[5] = '{21'h000001, 21'h1FFFFF, 21'h155555, 21'h100040, 21'h002001};
		foreach (t[i]) send(t[i]);
		foreach (t[i]) expect_word(t[i]);
	endtask
	task automatic t_hold;
		hold = 1'b1;
		cyc(3);
		send(21'h012345);
		send(21'h06789A);
		send(21'h1BCDEF);
		chk("ready", 21'h0, rdy);
		chk("held", 21'h0, 21'(rq.size()));
		hold = 1'b0;
		expect_word(21'h012345);
		expect_word(21'h06789A);
		cyc(3);
		send(21'h0F0F0F);
		expect_word(21'h0F0F0F);
	endtask
	task automatic t_shut;
		send(21'h1ABCDE);
		arst_n_i = 1'b0;
		#1;
		chk("drv_n", 21'h1, drv_n);
		chk("lanes", 21'h0, {fwd, ln});
		chk("ready", 21'h0, rdy);
		cyc(2);
		arst_n_i = 1'b1;
		cyc(12);
		rq.delete();
		send(21'h054321);
		expect_word(21'h054321);
	endtask
	task automatic test_done;
		$display("n_tests=%0d fails=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		t_reset();
		t_stream();
		t_hold();
		t_shut();
		test_done();
	end
	initial begin
		#20000;
		fails++;
		test_done();
	end
endmodule // test_tlsx_top
`default_nettype wire
